// ### ido_pkg.sv
// constants, register map and types of the serial audio output port
package ido_pkg;

  // ----------------------------------------------------------------
  // host memory map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_GPIO_DIR  = 16'hc017;
  localparam logic [15:0] ADDR_GPIO_OUT  = 16'hc018;
  localparam logic [15:0] ADDR_GPIO_IN   = 16'hc019;
  localparam logic [15:0] ADDR_I2S_CTRL  = 16'hc040;

  localparam logic [3:0]  RST_I2S_CTRL   = 4'h0;
  localparam logic [7:0]  RST_GPIO_DIR   = 8'h00;
  localparam logic [7:0]  RST_GPIO_OUT   = 8'h00;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_RATE_LSB  = 0;
  localparam int CTRL_PORT_EN   = 2;
  localparam int CTRL_MCLK_EN   = 3;

  localparam logic [1:0] RATE_48K  = 2'h0;
  localparam logic [1:0] RATE_96K  = 2'h1;
  localparam logic [1:0] RATE_192K = 2'h2;

  // bit clock half period in ticks (one tick is one master clock half period)
  localparam logic [3:0] HALF_48K  = 4'h8;
  localparam logic [3:0] HALF_96K  = 4'h4;
  localparam logic [3:0] HALF_192K = 4'h2;

  // ----------------------------------------------------------------
  // pin assignment inside the general-purpose bank
  // ----------------------------------------------------------------
  localparam int PIN_MCLK = 4;
  localparam int PIN_BCLK = 5;
  localparam int PIN_DATA = 6;
  localparam int PIN_WSEL = 7;

  localparam int WORD_BITS = 16;
  localparam logic [4:0] SLOT_LOAD = 5'h01;

  // ----------------------------------------------------------------
  // register index decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_DIR  = 3'b001,
    REG_OUT  = 3'b010,
    REG_IN   = 3'b011,
    REG_CTRL = 3'b100
  } ido_reg_type;

  typedef enum logic [0:0] {
    ST_OFF = 1'b0,
    ST_RUN = 1'b1
  } ido_state_type;

endpackage

// ### ido_clkgen.sv
// master clock and bit clock generator for the serial audio port
`timescale 1ns/100ps
module ido_clkgen
  import ido_pkg::*;
(
  input  wire logic       clk_i,        // device clock
  input  wire logic       rst_n_i,      // async reset, active low
  input  wire logic       run_i,        // port running
  input  wire logic       range_i,      // input clock range bit
  input  wire logic [1:0] rate_i,       // output rate select
  output logic            mclk_o,       // master clock level
  output logic            bclk_o,       // bit clock level
  output logic            bclk_fall_o   // pulse: bit clock just fell
);

  logic       pre;
  logic [3:0] cnt;
  logic       next_pre;
  logic       next_mclk;
  logic       next_bclk;
  logic       next_fall;
  logic [3:0] next_cnt;
  logic       tick;
  logic [3:0] half;

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  always_comb begin
    case (rate_i)                                          // R6
      RATE_96K:  half = HALF_96K;
      RATE_192K: half = HALF_192K;
      default:   half = HALF_48K;
    endcase
    next_pre  = run_i ? ~pre : 1'b0;
    tick      = run_i && (!range_i || pre);                // R4
    next_mclk = mclk_o;
    next_bclk = bclk_o;
    next_cnt  = cnt;
    next_fall = 1'b0;
    if (!run_i) begin
      next_mclk = 1'b0;
      next_bclk = 1'b0;
      next_cnt  = 4'h0;
    end else if (tick) begin
      next_mclk = ~mclk_o;
      if (cnt == half - 4'h1) begin                        // R6
        next_cnt  = 4'h0;
        next_bclk = ~bclk_o;
        next_fall = bclk_o;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre         <= 1'b0;
      cnt         <= 4'h0;
      mclk_o      <= 1'b0;
      bclk_o      <= 1'b0;
      bclk_fall_o <= 1'b0;
    end else begin
      pre         <= next_pre;
      cnt         <= next_cnt;
      mclk_o      <= next_mclk;
      bclk_o      <= next_bclk;
      bclk_fall_o <= next_fall;
    end
  end

endmodule

// ### ido_port.sv
// serial audio output port with shared general-purpose pins and host register access
//
// Contract
// R1: control bit 2 hands the shared pins to the audio port, else general-purpose.
// R2: after reset the port is off and all pins are inputs.
// R3: control bit 3 drives the master clock pin; clear means no master clock.
// R4: master clock follows input clock, or half of it when range bit is one.
// R5: rate field 00, 01, 10 selects 48, 96, 192 kHz output.
// R6: bit clock is master clock divided by 8, 4 or 2 by rate.
// R7: output rate is independent of source rate; samples are resampled.
// R8: host writes 0xf0 to 0xc017, then 0x0c to the control register.
// R9: audio signals appear on general-purpose pins 4 to 7.
// R10: software reset clears the pin direction register, audio pins included.
// R11: 16-bit MSB-first words, select toggles every 16 bit clocks, data one late.
`timescale 1ns/100ps
module ido_port
  import ido_pkg::*;
(
  input  wire logic        clk_i,          // device clock, 200 MHz
  input  wire logic        rst_n_i,        // async reset, active low
  input  wire logic        soft_reset_i,   // software reset pulse
  input  wire logic        range_bit_i,    // input clock range bit
  input  wire logic        host_wr_i,      // host write strobe
  input  wire logic        host_rd_i,      // host read strobe
  input  wire logic        host_sel_i,     // 0 address port, 1 data port
  input  wire logic [15:0] host_wdata_i,   // host write data
  output logic      [15:0] host_rdata_o,   // host read data
  output logic             host_rvalid_o,  // read data valid pulse
  input  wire logic        audio_valid_i,  // stereo sample offered
  input  wire logic [15:0] audio_left_i,   // left sample
  input  wire logic [15:0] audio_right_i,  // right sample
  output logic             audio_ready_o,  // port takes samples
  input  wire logic [7:0]  gpio_in_i,      // pin input levels
  output logic      [7:0]  gpio_out_o,     // pin output levels
  output logic      [7:0]  gpio_oe_o       // pin output enables
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic ido_reg_type reg_of(input logic [15:0] a);
    case (a)
      ADDR_GPIO_DIR: reg_of = REG_DIR;
      ADDR_GPIO_OUT: reg_of = REG_OUT;
      ADDR_GPIO_IN:  reg_of = REG_IN;
      ADDR_I2S_CTRL: reg_of = REG_CTRL;
      default:       reg_of = REG_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // host registers
  // ----------------------------------------------------------------
  logic [15:0]   addr;
  logic [3:0]    ctrl;
  logic [7:0]    dir;
  logic [7:0]    dout;
  logic [15:0]   next_addr;
  logic [3:0]    next_ctrl;
  logic [7:0]    next_dir;
  logic [7:0]    next_dout;
  logic [15:0]   next_rdata;
  logic          next_rvalid;
  ido_reg_type   sel_reg;

  always_comb begin
    next_addr   = addr;
    next_ctrl   = ctrl;
    next_dir    = dir;
    next_dout   = dout;
    next_rdata  = host_rdata_o;
    next_rvalid = 1'b0;
    sel_reg     = reg_of(addr);
    if (host_wr_i && !host_sel_i) begin
      next_addr = host_wdata_i;
    end else if (host_wr_i && host_sel_i) begin             // R8
      case (sel_reg)
        REG_DIR:  next_dir  = host_wdata_i[7:0];
        REG_OUT:  next_dout = host_wdata_i[7:0];
        REG_CTRL: next_ctrl = host_wdata_i[3:0];
        default:  next_dir  = dir;
      endcase
    end
    if (host_rd_i) begin
      next_rvalid = 1'b1;
      if (!host_sel_i) begin
        next_rdata = addr;
      end else begin
        case (sel_reg)
          REG_DIR:  next_rdata = {8'h00, dir};
          REG_OUT:  next_rdata = {8'h00, dout};
          REG_IN:   next_rdata = {8'h00, gpio_in_i};
          REG_CTRL: next_rdata = {12'h000, ctrl};
          default:  next_rdata = 16'h0000;
        endcase
      end
    end
    if (soft_reset_i) begin
      next_dir = RST_GPIO_DIR;                              // R10
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr          <= 16'h0000;
      ctrl          <= RST_I2S_CTRL;                        // R2
      dir           <= RST_GPIO_DIR;                        // R2
      dout          <= RST_GPIO_OUT;
      host_rdata_o  <= 16'h0000;
      host_rvalid_o <= 1'b0;
    end else begin
      addr          <= next_addr;
      ctrl          <= next_ctrl;
      dir           <= next_dir;
      dout          <= next_dout;
      host_rdata_o  <= next_rdata;
      host_rvalid_o <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------
  ido_state_type state;
  ido_state_type next_state;
  logic          mclk;
  logic          bclk;
  logic          bclk_fall;

  ido_clkgen u_clkgen (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .run_i       (state == ST_RUN),
    .range_i     (range_bit_i),
    .rate_i      (ctrl[CTRL_RATE_LSB +: 2]),                // R5
    .mclk_o      (mclk),
    .bclk_o      (bclk),
    .bclk_fall_o (bclk_fall)
  );

  // ----------------------------------------------------------------
  // framing and sample hold
  // ----------------------------------------------------------------
  logic [15:0] hold_l;
  logic [15:0] hold_r;
  logic [31:0] shreg;
  logic [4:0]  slot;
  logic        wsel;
  logic        sdata;
  logic [15:0] next_hold_l;
  logic [15:0] next_hold_r;
  logic [31:0] next_shreg;
  logic [4:0]  next_slot;
  logic        next_wsel;
  logic        next_sdata;
  logic        next_ready;

  always_comb begin
    next_state  = ctrl[CTRL_PORT_EN] ? ST_RUN : ST_OFF;      // R1
    next_hold_l = hold_l;
    next_hold_r = hold_r;
    next_shreg  = shreg;
    next_slot   = slot;
    next_wsel   = wsel;
    next_sdata  = sdata;
    next_ready  = (next_state == ST_RUN);
    // latest sample wins: repeats or drops give zero-order-hold conversion
    if (audio_valid_i && audio_ready_o) begin                // R7
      next_hold_l = audio_left_i;
      next_hold_r = audio_right_i;
    end
    case (state)
      ST_OFF: begin
        next_shreg = 32'h0000_0000;
        next_slot  = 5'h00;
        next_wsel  = 1'b0;
        next_sdata = 1'b0;
      end
      ST_RUN: begin
        if (bclk_fall) begin                                 // R11
          next_slot = slot + 5'h01;
          next_wsel = next_slot[4];
          if (next_slot == SLOT_LOAD) begin
            next_shreg = {hold_l, hold_r};
            next_sdata = hold_l[WORD_BITS-1];
          end else begin
            next_shreg = {shreg[30:0], 1'b0};
            next_sdata = shreg[30];
          end
        end
      end
      default: next_slot = 5'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state         <= ST_OFF;
      hold_l        <= 16'h0000;
      hold_r        <= 16'h0000;
      shreg         <= 32'h0000_0000;
      slot          <= 5'h00;
      wsel          <= 1'b0;
      sdata         <= 1'b0;
      audio_ready_o <= 1'b0;
    end else begin
      state         <= next_state;
      hold_l        <= next_hold_l;
      hold_r        <= next_hold_r;
      shreg         <= next_shreg;
      slot          <= next_slot;
      wsel          <= next_wsel;
      sdata         <= next_sdata;
      audio_ready_o <= next_ready;
    end
  end

  // ----------------------------------------------------------------
  // pin mux
  // ----------------------------------------------------------------
  logic [7:0] next_pout;
  logic [7:0] next_poe;
  logic       run;

  always_comb begin
    run       = (state == ST_RUN);
    next_pout = dout;
    next_poe  = dir;
    if (run) begin                                           // R1
      // audio pins still need their direction bits, lost on soft reset
      next_pout[PIN_MCLK] = mclk && ctrl[CTRL_MCLK_EN];      // R9
      next_pout[PIN_BCLK] = bclk;
      next_pout[PIN_DATA] = sdata;
      next_pout[PIN_WSEL] = wsel;
      next_poe[PIN_MCLK]  = dir[PIN_MCLK] && ctrl[CTRL_MCLK_EN]; // R3
      next_poe[PIN_BCLK]  = dir[PIN_BCLK];                   // R10
      next_poe[PIN_DATA]  = dir[PIN_DATA];
      next_poe[PIN_WSEL]  = dir[PIN_WSEL];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gpio_out_o <= 8'h00;
      gpio_oe_o  <= 8'h00;                                   // R2
    end else begin
      gpio_out_o <= next_pout;
      gpio_oe_o  <= next_poe;
    end
  end

endmodule

// ### ido_port_checker.sv
// assertions on the serial audio output port pins and host strobes
`timescale 1ns/100ps
module ido_port_checker
  import ido_pkg::*;
(
  input wire logic       clk_i,         // device clock
  input wire logic       rst_n_i,       // async reset, active low
  input wire logic       soft_reset_i,  // software reset
  input wire logic       range_bit_i,   // clock range bit
  input wire logic       host_wr_i,     // write strobe
  input wire logic       host_rd_i,     // read strobe
  input wire logic       host_sel_i,    // port select
  input wire logic       host_rvalid_o, // read valid
  input wire logic       audio_ready_o, // port running
  input wire logic [7:0] gpio_out_o,    // pin levels
  input wire logic [7:0] gpio_oe_o      // pin enables
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic mk = gpio_out_o[PIN_MCLK];
  wire logic bk = gpio_out_o[PIN_BCLK];

  reset_idle_a: assert property ($rose(rst_n_i) |-> gpio_oe_o == 8'h00 && !audio_ready_o)
    else $error("pins or port active after reset");
  ready_cause_a: assert property ($rose(audio_ready_o) |->
    $past(host_wr_i && host_sel_i, 2) || $past(host_wr_i && host_sel_i, 3))
    else $error("port started without a data port write");
  mclk_full_a: assert property (!range_bit_i && gpio_oe_o[4] && $rose(mk) ##1 gpio_oe_o[4]
    |-> !mk)
    else $error("master clock not input rate");
  mclk_half_a: assert property (range_bit_i && gpio_oe_o[4] && $rose(mk) ##1 gpio_oe_o[4] [*2]
    |-> !mk && $past(mk))
    else $error("master clock not half input rate");
  bclk_hold_a: assert property (gpio_oe_o[5] && $changed(bk) ##1 gpio_oe_o[5] |-> $stable(bk))
    else $error("bit clock half period too short");
  wsel_edge_a: assert property (audio_ready_o && gpio_oe_o[7] && $past(gpio_oe_o[7])
    && $changed(gpio_out_o[7]) |-> !bk)
    else $error("word select moved while bit clock high");
  data_edge_a: assert property (audio_ready_o && gpio_oe_o[6] && $past(gpio_oe_o[6])
    && $changed(gpio_out_o[6]) |-> !bk)
    else $error("data moved while bit clock high");
  rvalid_cause_a: assert property (!host_rd_i |=> !host_rvalid_o)
    else $error("read valid without read");
  soft_clear_a: assert property (soft_reset_i |-> ##[1:2] gpio_oe_o == 8'h00)
    else $error("soft reset left pin enables");

  cover property ($rose(audio_ready_o));
  cover property (host_rvalid_o);
  cover property (soft_reset_i);
endmodule

bind ido_port ido_port_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .soft_reset_i(soft_reset_i), .range_bit_i(range_bit_i), .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i), .host_sel_i(host_sel_i), .host_rvalid_o(host_rvalid_o),
  .audio_ready_o(audio_ready_o), .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o));

// ### ido_dac_model.sv
// external converter model: samples serial audio on bit clock rises
`timescale 1ns/100ps
module ido_dac_model (
  input  wire logic        bclk_i,  // bit clock pin
  input  wire logic        wsel_i,  // word select pin
  input  wire logic        data_i,  // serial data pin
  output logic      [15:0] left_o,  // last left word
  output logic      [15:0] right_o  // last right word
);
  logic [15:0] sh = 16'h0000;
  logic        ws_q = 1'b0;
  always @(posedge bclk_i) begin
    sh <= {sh[14:0], data_i};
    ws_q <= wsel_i;
    // lsb rides the same slot in which select toggles
    if (wsel_i != ws_q) begin
      if (ws_q) right_o <= {sh[14:0], data_i};
      else left_o <= {sh[14:0], data_i};
    end
  end
endmodule

// ### tb.sv
// self-checking bench for the serial audio output port
`timescale 1ns/100ps
module tb;
  import ido_pkg::*;
  logic        clk_i = 0, rst_n_i = 0, soft_reset_i = 0, range_bit_i = 0;
  logic        host_wr_i = 0, host_rd_i = 0, host_sel_i = 0, audio_valid_i = 0;
  logic [15:0] host_wdata_i = 0, audio_left_i = 0, audio_right_i = 0;
  logic [15:0] host_rdata_o, dl, dr;
  logic        host_rvalid_o, audio_ready_o;
  logic [7:0]  gpio_out_o, gpio_oe_o, pin, ext = 8'h00;
  logic [15:0] expq[$];
  int          num_errors = 0, cmp_count = 0, n;
  // pin level resolves driver against the outside world
  assign pin = (gpio_oe_o & gpio_out_o) | (~gpio_oe_o & ext);
  always #2.5 clk_i = ~clk_i;
  ido_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i),
    .range_bit_i(range_bit_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .host_sel_i(host_sel_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o), .audio_valid_i(audio_valid_i), .audio_left_i(audio_left_i),
    .audio_right_i(audio_right_i), .audio_ready_o(audio_ready_o), .gpio_in_i(pin),
    .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o));
  ido_dac_model dac (.bclk_i(pin[PIN_BCLK]), .wsel_i(pin[PIN_WSEL]), .data_i(pin[PIN_DATA]),
    .left_o(dl), .right_o(dr));

  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic sel, logic [15:0] d);
    @(negedge clk_i);
    host_sel_i = sel;
    host_wdata_i = d;
    host_wr_i = 1;
    @(negedge clk_i);
    host_wr_i = 0;
  endtask
  task automatic reg_wr(logic [15:0] a, logic [15:0] d);
    wr(0, a);
    wr(1, d);
    repeat (3) @(negedge clk_i);
  endtask
  task automatic reg_rd(logic [15:0] a, logic [15:0] e);
    wr(0, a);
    expq.push_back(e);
    @(negedge clk_i);
    host_sel_i = 1;
    host_rd_i = 1;
    @(negedge clk_i);
    host_rd_i = 0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic wait_pin(int b, logic v);
    for (int i = 0; i < 4000 && pin[b] !== v; i++) begin
      @(negedge clk_i);
      n++;
    end
    if (pin[b] !== v) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic period(int b, int e, string nm);
    wait_pin(b, 0);
    wait_pin(b, 1);
    n = 0;
    wait_pin(b, 0);
    wait_pin(b, 1);
    chk(nm, 16'(n), 16'(e));
  endtask

  // read valid stands one cycle: look at it mid-cycle, clear of the launching edge
  always @(negedge clk_i) if (host_rvalid_o === 1'b1) begin
    if (expq.size() == 0) chk("spare read", 16'h0001, 16'h0000);
    else chk("read data", host_rdata_o, expq.pop_front());
  end

  initial begin
    n = $urandom(26);
    ext = 8'($urandom);
    repeat (5) @(negedge clk_i);
    rst_n_i = 1;
    chk("oe after reset", 16'(gpio_oe_o), 16'h0000);
    reg_rd(ADDR_I2S_CTRL, 16'h0000);
    reg_rd(ADDR_GPIO_IN, {8'h00, ext});
    reg_rd(16'hc041, 16'h0000);
    audio_valid_i = 1;
    for (int r = 0; r < 2; r++) for (int s = 0; s < 3; s++) begin
      audio_left_i = 16'($urandom);
      audio_right_i = 16'($urandom);
      reg_wr(ADDR_GPIO_DIR, 16'h0000);
      reg_wr(ADDR_I2S_CTRL, 16'h0000);
      range_bit_i = r[0];
      reg_wr(ADDR_GPIO_DIR, 16'h00f0);
      reg_wr(ADDR_I2S_CTRL, 16'h000c | 16'(s));
      chk("ready", 16'(audio_ready_o), 16'h0001);
      chk("audio pins oe", 16'(gpio_oe_o[7:4]), 16'h000f);
      reg_rd(ADDR_I2S_CTRL, 16'h000c | 16'(s));
      period(PIN_MCLK, 2 * (r + 1), "mclk period");
      period(PIN_BCLK, 2 * (r + 1) * (8 >> s), "bclk period");
      repeat (96 * (r + 1) * (8 >> s)) @(negedge clk_i);
      chk("left word", dl, audio_left_i);
      chk("right word", dr, audio_right_i);
    end
    reg_wr(ADDR_I2S_CTRL, 16'h0004);
    chk("mclk oe", 16'(gpio_oe_o[PIN_MCLK]), 16'h0000);
    chk("bclk oe", 16'(gpio_oe_o[PIN_BCLK]), 16'h0001);
    // new sample while running must reach a later frame
    audio_left_i = 16'($urandom);
    repeat (2200) @(negedge clk_i);
    chk("latest left", dl, audio_left_i);
    @(negedge clk_i);
    soft_reset_i = 1;
    @(negedge clk_i);
    soft_reset_i = 0;
    repeat (3) @(negedge clk_i);
    chk("oe after soft reset", 16'(gpio_oe_o), 16'h0000);
    reg_rd(ADDR_GPIO_DIR, 16'h0000);
    reg_rd(ADDR_I2S_CTRL, 16'h0004);
    reg_wr(ADDR_I2S_CTRL, 16'h0000);
    reg_wr(ADDR_GPIO_DIR, 16'h00e0);
    reg_wr(ADDR_GPIO_OUT, 16'h00a0);
    chk("gpio pins", 16'(pin[7:4]), 16'({3'b101, ext[4]}));
    reg_rd(ADDR_GPIO_OUT, 16'h00a0);
    rst_n_i = 0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1;
    reg_rd(ADDR_GPIO_DIR, 16'h0000);
    repeat (3) @(negedge clk_i);
    chk("reads pending", 16'(expq.size()), 16'h0000);
    test_done();
  end
endmodule
